// >>> core/spirq_pkg.sv
package spirq_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map, word aligned byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_LEVEL_SEL = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_RAW = 8'h08;
  localparam logic [7:0] OFF_MASKED = 8'h0c;
  localparam logic [7:0] OFF_CLEAR = 8'h10;

  ////////////////////////////////////////////////////////////////////////
  // Trigger level selector fields
  localparam int unsigned SEL_W = 3;
  localparam int unsigned RX_SEL_LSB = 3;
  localparam int unsigned TX_SEL_LSB = 0;
  localparam logic [2:0] SEL_RESET = 3'h2;
  localparam logic [2:0] SEL_MAX = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt source positions, shared by mask, raw, masked and clear
  localparam int unsigned SRC_W = 11;
  localparam int unsigned BIT_OVERRUN = 10;
  localparam int unsigned BIT_BREAK = 9;
  localparam int unsigned BIT_PARITY = 8;
  localparam int unsigned BIT_FRAMING = 7;
  localparam int unsigned BIT_RX_TIMEOUT = 6;
  localparam int unsigned BIT_TX_LEVEL = 5;
  localparam int unsigned BIT_RX_LEVEL = 4;
  localparam int unsigned BIT_CTS_CHANGE = 1;
  localparam logic [10:0] SRC_USED = 11'h7f2;
  localparam logic [10:0] MASK_RESET = 11'h000;
  localparam logic [10:0] RAW_RESET = 11'h000;

  // Trigger point in eighths of the FIFO; zero marks a reserved code
  function automatic logic [3:0] spirq_eighths(input logic [2:0] sel);
    case (sel)
      3'h0: spirq_eighths = 4'h1;
      3'h1: spirq_eighths = 4'h2;
      3'h2: spirq_eighths = 4'h4;
      3'h3: spirq_eighths = 4'h6;
      3'h4: spirq_eighths = 4'h7;
      default: spirq_eighths = 4'h0;
    endcase
  endfunction : spirq_eighths

  // Fill count threshold for a selector at a given depth
  function automatic int unsigned spirq_threshold(input logic [2:0] sel,
                                                  input int unsigned depth);
    spirq_threshold = (depth * int'(spirq_eighths(sel))) / 8;
  endfunction : spirq_threshold

endpackage : spirq_pkg

// >>> core/spirq_level_cross.sv
`timescale 1ns/10ps
module spirq_level_cross
  import spirq_pkg::*;
#(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned FILL_W = $clog2(DEPTH + 1),
  parameter bit RISING = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [FILL_W-1:0] i_fill,
  input wire logic [2:0] i_sel,
  output logic o_cross
);

  if (DEPTH < 8 || (DEPTH % 8) != 0) begin : g_chk
    $error("spirq_level_cross: DEPTH must be a multiple of 8");
  end

  logic [FILL_W-1:0] prev_fill;
  logic [FILL_W-1:0] thresh;
  logic sel_ok;

  ////////////////////////////////////////////////////////////////////////
  // Threshold scales with the parameterised depth
  assign thresh = FILL_W'(spirq_threshold(i_sel, DEPTH));
  assign sel_ok = (spirq_eighths(i_sel) != 4'h0);

  // Last fill count, so a crossing can be told from a standing level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_fill <= '0;
    end else begin
      prev_fill <= i_fill;
    end
  end

  // Fill rising through the point, or draining through it for transmit
  always_comb begin
    if (!sel_ok) begin
      o_cross = 1'b0;
    end else if (RISING) begin
      o_cross = (prev_fill < thresh) && (i_fill >= thresh);
    end else begin
      o_cross = (prev_fill > thresh) && (i_fill <= thresh);
    end
  end

endmodule : spirq_level_cross

// >>> core/spirq_cts_watch.sv
`timescale 1ns/10ps
module spirq_cts_watch (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clear_to_send_in_n,
  output logic o_change
);

  logic prev_cts_n;
  logic primed;

  ////////////////////////////////////////////////////////////////////////
  // First sample only primes; reset value of the pin is not known
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_cts_n <= 1'b1;
      primed <= 1'b0;
    end else begin
      prev_cts_n <= i_clear_to_send_in_n;
      primed <= 1'b1;
    end
  end

  // Any edge on the modem input is a change event
  assign o_change = primed && (prev_cts_n != i_clear_to_send_in_n);

endmodule : spirq_cts_watch

// >>> core/spirq_core.sv
`timescale 1ns/10ps
module spirq_core
  import spirq_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned FILL_W = $clog2(FIFO_DEPTH + 1)
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [FILL_W-1:0] i_rx_fill,
  input wire logic [FILL_W-1:0] i_tx_fill,
  input wire logic i_overrun_evt,
  input wire logic i_break_evt,
  input wire logic i_parity_evt,
  input wire logic i_framing_evt,
  input wire logic i_rx_timeout_evt,
  input wire logic i_clear_to_send_in_n,
  output logic [31:0] o_rdata,
  output logic [SRC_W-1:0] o_masked,
  output logic o_irq
);

  if (FIFO_DEPTH < 8 || (FIFO_DEPTH % 8) != 0) begin : g_chk
    $error("spirq_core: FIFO_DEPTH must be a multiple of 8");
  end

  logic [2:0] rx_trigger_sel;
  logic [2:0] tx_trigger_sel;
  logic [SRC_W-1:0] mask;
  logic [SRC_W-1:0] raw;
  logic [SRC_W-1:0] next_mask;
  logic [SRC_W-1:0] next_raw;
  logic [SRC_W-1:0] set_vec;
  logic [SRC_W-1:0] clr_vec;
  logic [31:0] next_rdata;
  logic rx_cross;
  logic tx_cross;
  logic cts_change;
  logic wr_level;
  logic wr_mask;
  logic wr_clear;
  logic [2:0] wr_rx_sel;
  logic [2:0] wr_tx_sel;

  ////////////////////////////////////////////////////////////////////////
  // Event sources
  spirq_level_cross #(
    .DEPTH(FIFO_DEPTH),
    .FILL_W(FILL_W),
    .RISING(1'b1)
  ) u_rx_cross (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_fill(i_rx_fill),
    .i_sel(rx_trigger_sel),
    .o_cross(rx_cross)
  );

  // Transmit level fires as the FIFO drains through its point
  spirq_level_cross #(
    .DEPTH(FIFO_DEPTH),
    .FILL_W(FILL_W),
    .RISING(1'b0)
  ) u_tx_cross (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_fill(i_tx_fill),
    .i_sel(tx_trigger_sel),
    .o_cross(tx_cross)
  );

  spirq_cts_watch u_cts (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear_to_send_in_n(i_clear_to_send_in_n),
    .o_change(cts_change)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register decode; unaligned or unmapped addresses hit nothing
  assign wr_level = i_wr && (i_addr == OFF_LEVEL_SEL);
  assign wr_mask = i_wr && (i_addr == OFF_MASK);
  assign wr_clear = i_wr && (i_addr == OFF_CLEAR);
  assign wr_rx_sel = i_wdata[RX_SEL_LSB +: SEL_W];
  assign wr_tx_sel = i_wdata[TX_SEL_LSB +: SEL_W];

  // Trigger selectors; a reserved code leaves the old setting in place
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_trigger_sel <= SEL_RESET;
      tx_trigger_sel <= SEL_RESET;
    end else if (wr_level) begin
      if (wr_rx_sel <= SEL_MAX) begin
        rx_trigger_sel <= wr_rx_sel;
      end
      if (wr_tx_sel <= SEL_MAX) begin
        tx_trigger_sel <= wr_tx_sel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mask: unsupported modem bits stay zero whatever is written
  always_comb begin
    next_mask = mask;
    if (wr_mask) begin
      next_mask = i_wdata[SRC_W-1:0] & SRC_USED;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask <= MASK_RESET;
    end else begin
      mask <= next_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky raw status; a new event beats a clear in the same cycle
  always_comb begin
    set_vec = '0;
    set_vec[BIT_OVERRUN] = i_overrun_evt;
    set_vec[BIT_BREAK] = i_break_evt;
    set_vec[BIT_PARITY] = i_parity_evt;
    set_vec[BIT_FRAMING] = i_framing_evt;
    set_vec[BIT_RX_TIMEOUT] = i_rx_timeout_evt;
    set_vec[BIT_TX_LEVEL] = tx_cross;
    set_vec[BIT_RX_LEVEL] = rx_cross;
    set_vec[BIT_CTS_CHANGE] = cts_change;
    clr_vec = wr_clear ? (i_wdata[SRC_W-1:0] & SRC_USED) : '0;
    next_raw = ((raw & ~clr_vec) | set_vec) & SRC_USED;
  end

  // Modem bits are reset too: a known zero is one of the allowed values
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      raw <= RAW_RESET;
    end else begin
      raw <= next_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Masked view and interrupt, from next values so they track raw and mask
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_masked <= '0;
      o_irq <= 1'b0;
    end else begin
      o_masked <= next_raw & next_mask;
      o_irq <= |(next_raw & next_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; clear register and unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        OFF_LEVEL_SEL: begin
          next_rdata[RX_SEL_LSB +: SEL_W] = rx_trigger_sel;
          next_rdata[TX_SEL_LSB +: SEL_W] = tx_trigger_sel;
        end
        OFF_MASK: next_rdata[SRC_W-1:0] = mask;
        OFF_RAW: next_rdata[SRC_W-1:0] = raw;
        OFF_MASKED: next_rdata[SRC_W-1:0] = raw & mask;
        default: next_rdata = '0;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic post_rst;
  logic no_evt;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      post_rst <= 1'b0;
    end else begin
      post_rst <= 1'b1;
    end
  end

  assign no_evt = (set_vec == '0);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_clear_quiet;
    wr_clear && no_evt;
  endsequence

  sequence s_raw_write_quiet;
    i_wr && (i_addr == OFF_RAW) && no_evt;
  endsequence

  // Clear arriving in the same cycle as a new event
  sequence s_clear_collide;
    wr_clear && !no_evt;
  endsequence

  AST_RESET_SEL: assert property (
    !post_rst |-> (rx_trigger_sel == 3'h2) && (tx_trigger_sel == 3'h2))
    else $error("selectors not half-full after reset");

  AST_RESET_RAW: assert property (
    !post_rst |-> (raw == '0) && (mask == '0))
    else $error("status or mask not zero after reset");

  AST_RX_CROSS: assert property (
    $rose(raw[BIT_RX_LEVEL]) |-> $past(rx_cross))
    else $error("receive level set without a crossing");

  AST_RX_RESERVED: assert property (
    wr_level && (wr_rx_sel > 3'h4) |=> $stable(rx_trigger_sel))
    else $error("reserved receive code was stored");

  AST_TX_RESERVED: assert property (
    wr_level && (wr_tx_sel > 3'h4) |=> $stable(tx_trigger_sel))
    else $error("reserved transmit code was stored");

  AST_UNUSED_ZERO: assert property (
    (o_rdata[31:12] == '0) && ((mask & ~SRC_USED) == '0))
    else $error("unsupported bits not zero");

  AST_MASK_READ: assert property (
    i_rd && (i_addr == OFF_MASK) && !i_wr
      |=> o_rdata == {21'h0, $past(mask)})
    else $error("mask readback wrong");

  AST_MASK_WRITE: assert property (
    wr_mask |=> mask == ($past(i_wdata[10:0]) & 11'h7f2))
    else $error("mask write not taken");

  AST_RAW_RO: assert property (
    s_raw_write_quiet |=> $stable(raw))
    else $error("raw status changed by a write");

  AST_CLEAR: assert property (
    s_clear_quiet |=> (raw & $past(i_wdata[10:0])) == '0)
    else $error("clear did not clear raw status");

  AST_SET_WINS: assert property (
    i_overrun_evt |=> raw[10] && o_masked[10] == mask[10])
    else $error("overrun event lost");

  AST_IRQ: assert property (
    (o_irq == |(raw & mask)) && (o_masked == (raw & mask)))
    else $error("interrupt output disagrees with status");

  AST_SET_OVER_CLEAR: assert property (
    s_clear_collide |=> (raw & $past(set_vec)) == $past(set_vec))
    else $error("clear beat a same-cycle event");

  AST_TX_CROSS: assert property (
    $rose(raw[BIT_TX_LEVEL]) |-> $past(tx_cross))
    else $error("transmit level set without a crossing");

  AST_CTS_EDGE: assert property (
    $rose(raw[BIT_CTS_CHANGE]) |-> $past(cts_change))
    else $error("modem change set without a pin edge");

  AST_RAW_READ: assert property (
    i_rd && (i_addr == OFF_RAW) |=> o_rdata == {21'h0, $past(raw)})
    else $error("raw status readback wrong");

  AST_MASKED_READ: assert property (
    i_rd && (i_addr == OFF_MASKED)
      |=> o_rdata == {21'h0, $past(raw) & $past(mask)})
    else $error("masked status readback wrong");

  AST_RX_SEL_WRITE: assert property (
    wr_level && (wr_rx_sel <= SEL_MAX)
      |=> rx_trigger_sel == $past(wr_rx_sel))
    else $error("receive selector write not taken");

  AST_TX_SEL_WRITE: assert property (
    wr_level && (wr_tx_sel <= SEL_MAX)
      |=> tx_trigger_sel == $past(wr_tx_sel))
    else $error("transmit selector write not taken");

endmodule : spirq_core

// >>> sim/spirq_core_tb.sv
`timescale 1ns/10ps
module spirq_core_tb;
  import spirq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Small FIFO keeps the level sweeps short
  localparam int unsigned DEPTH = 8;
  localparam int unsigned FW = $clog2(DEPTH + 1);
  localparam int TH[5] = '{1, 2, 4, 6, 7};

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [FW-1:0] rxf = '0;
  logic [FW-1:0] txf = '0;
  logic [4:0] ev = '0;
  logic cts_n = 1'b1;
  logic [31:0] rdata;
  logic [SRC_W-1:0] masked;
  logic irq;
  int n_errors = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  spirq_core #(.FIFO_DEPTH(DEPTH)) dut (
    .i_clk(clk),
    .i_rst(rst),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr_s),
    .i_rd(rd_s),
    .i_rx_fill(rxf),
    .i_tx_fill(txf),
    .i_overrun_evt(ev[4]),
    .i_break_evt(ev[3]),
    .i_parity_evt(ev[2]),
    .i_framing_evt(ev[1]),
    .i_rx_timeout_evt(ev[0]),
    .i_clear_to_send_in_n(cts_n),
    .o_rdata(rdata),
    .o_masked(masked),
    .o_irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic finish_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask : rd_chk

  // Fill counts settle for a few edges before status is read
  task automatic set_fill(input int r, input int t);
    @(posedge clk);
    rxf <= r[FW-1:0];
    txf <= t[FW-1:0];
    repeat (3) @(posedge clk);
  endtask : set_fill

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rd_chk(OFF_LEVEL_SEL, 32'h12, "sel_rst");
    rd_chk(OFF_MASK, 32'h0, "mask_rst");
    rd_chk(OFF_RAW, 32'h0, "raw_rst");
    chk("irq_rst", 32'h0, {31'h0, irq});
  endtask : t_reset

  task automatic t_sel;
    for (int c = 0; c < 5; c++) begin
      wr(OFF_LEVEL_SEL, 32'((c << 3) | (4 - c)));
      rd_chk(OFF_LEVEL_SEL, 32'((c << 3) | (4 - c)), "sel");
    end
    // Reserved rx code dropped with tx taken, then reserved tx dropped with rx taken; unused bits stay zero
    wr(OFF_LEVEL_SEL, 32'hfe9);
    rd_chk(OFF_LEVEL_SEL, 32'h21, "sel_rx_res");
    wr(OFF_LEVEL_SEL, 32'h17);
    rd_chk(OFF_LEVEL_SEL, 32'h11, "sel_tx_res");
  endtask : t_sel

  task automatic t_mask;
    wr(OFF_MASK, 32'hffffffff);
    rd_chk(OFF_MASK, 32'h7f2, "mask_all");
    wr(OFF_MASK, 32'h402);
    rd_chk(OFF_MASK, 32'h402, "mask_some");
    wr(OFF_MASK, 32'h0);
    rd_chk(OFF_MASK, 32'h0, "mask_none");
  endtask : t_mask

  task automatic t_events;
    logic [31:0] b;
    for (int k = 0; k < 5; k++) begin
      b = 32'h1 << (6 + k);
      @(posedge clk);
      ev <= 5'h1 << k;
      @(posedge clk);
      ev <= 5'h0;
      rd_chk(OFF_RAW, b, "raw_evt");
      chk("irq_off", 32'h0, {31'h0, irq});
      wr(OFF_MASK, b);
      chk("irq_on", 32'h1, {31'h0, irq});
      chk("masked", b, {21'h0, masked});
      rd_chk(OFF_MASKED, b, "masked_rd");
      // Raw status takes no writes
      wr(OFF_RAW, 32'h0);
      rd_chk(OFF_RAW, b, "raw_ro");
      wr(OFF_CLEAR, b);
      rd_chk(OFF_RAW, 32'h0, "raw_clr");
      chk("irq_clr", 32'h0, {31'h0, irq});
      wr(OFF_MASK, 32'h0);
    end
  endtask : t_events

  // Fires on passing the point, not on sitting beyond it
  task automatic t_levels;
    for (int c = 0; c < 5; c++) begin
      wr(OFF_LEVEL_SEL, 32'((c << 3) | c));
      set_fill(0, DEPTH);
      wr(OFF_CLEAR, 32'h7f2);
      set_fill(TH[c] - 1, DEPTH);
      rd_chk(OFF_RAW, 32'h0, "rx_below");
      set_fill(TH[c], TH[c] + 1);
      rd_chk(OFF_RAW, 32'h10, "rx_cross");
      wr(OFF_CLEAR, 32'h10);
      set_fill(DEPTH, TH[c] + 1);
      rd_chk(OFF_RAW, 32'h0, "rx_sit");
      set_fill(DEPTH, TH[c]);
      rd_chk(OFF_RAW, 32'h20, "tx_cross");
      wr(OFF_CLEAR, 32'h20);
      set_fill(DEPTH, 0);
      rd_chk(OFF_RAW, 32'h0, "tx_sit");
    end
  endtask : t_levels

  task automatic t_cts;
    wr(OFF_MASK, 32'h2);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      cts_n <= ~cts_n;
      repeat (3) @(posedge clk);
      rd_chk(OFF_RAW, 32'h2, "cts_raw");
      chk("cts_irq", 32'h1, {31'h0, irq});
      wr(OFF_CLEAR, 32'h2);
      rd_chk(OFF_RAW, 32'h0, "cts_clr");
    end
    rd_chk(OFF_CLEAR, 32'h0, "clr_rd");
    rd_chk(8'h14, 32'h0, "unmapped");
  endtask : t_cts

  // Event and clear in one cycle: the event must survive
  task automatic t_set_wins;
    @(posedge clk);
    ev <= 5'h10;
    addr <= OFF_CLEAR;
    wdata <= 32'h400;
    wr_s <= 1'b1;
    @(posedge clk);
    ev <= 5'h0;
    wr_s <= 1'b0;
    rd_chk(OFF_RAW, 32'h400, "raw_set_wins");
    wr(OFF_CLEAR, 32'h400);
    rd_chk(OFF_RAW, 32'h0, "raw_clr_after");
  endtask : t_set_wins

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_sel;
    t_mask;
    t_events;
    t_levels;
    t_cts;
    t_set_wins;
    finish_test;
  end

  // Watchdog, well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test;
  end

endmodule : spirq_core_tb
